// [gpsl_regs.vh]
// Purpose: Constants for the general-pin settings loader.
// Assumes: Register bus is AXI4-Lite with 32-bit data, one register per word.
// Notes: Command bytes land in byte-lane registers before the apply strobe.
`ifndef GPSL_REGS_VH
`define GPSL_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define GPSL_ADDR_CMD 8'h00
`define GPSL_ADDR_STATUS 8'h04
`define GPSL_ADDR_PINB 8'h08
`define GPSL_ADDR_PINC 8'h0C
`define GPSL_ADDR_PIND 8'h10
`define GPSL_ADDR_PINS_IN 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPSL_CMD_ALTER_BIT 7
`define GPSL_CMD_GO_BIT 8
`define GPSL_PIN_LEVEL_BIT 4
`define GPSL_PIN_DIR_BIT 3
`define GPSL_PIN_FUNC_MSB 2

// ----------------------------------------
// Function selector codes
// ----------------------------------------
`define GPSL_FUNC_GPIO 3'h0
`define GPSL_FUNC_DEDICATED 3'h1
`define GPSL_FUNC_ALT0 3'h2
`define GPSL_FUNC_ALT1 3'h3
`define GPSL_FUNC_ALT2 3'h4

// ----------------------------------------
// Response and reset values
// ----------------------------------------
`define GPSL_RESP_ECHO 8'h60
`define GPSL_RESP_OK 8'h00
`define GPSL_PIN_RESET 8'h08

`endif

// [gpsl_loader.v]
// Purpose: Loads run-time settings of three general pins and drives the pin muxes.
// Assumes: One clock; inputs synchronous to aclk; one AXI4-Lite transfer per channel pair.
// Notes: Software writes command byte 7 with a go bit; bytes 9..11 are staged first.
`timescale 1ns/1ps
`include "gpsl_regs.vh"

module gpsl_loader (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Dedicated and alternate sources for pin b
    input wire clock_output_src,
    input wire transmit_activity_indicator,
    // Dedicated and alternate sources for pins c and d
    input wire usb_configured_indicator,
    input wire serial_bus_activity_indicator,
    input wire analog_output_first,
    input wire analog_output_second,
    // Pin b
    input wire general_pin_b_in,
    output reg general_pin_b_out,
    output reg general_pin_b_oe_n,
    output reg analog_input_first_en,
    output reg edge_detect_en,
    output reg edge_detect_in,
    // Pin c
    input wire general_pin_c_in,
    output reg general_pin_c_out,
    output reg general_pin_c_oe_n,
    output reg analog_input_second_en,
    // Pin d
    input wire general_pin_d_in,
    output reg general_pin_d_out,
    output reg general_pin_d_oe_n,
    output reg analog_input_third_en,
    // Response strobe, one cycle, with its two bytes
    output reg resp_valid,
    output reg [7:0] resp_echo,
    output reg [7:0] resp_status
);

    // ----------------------------------------
    // Settings storage
    // ----------------------------------------
    // Staged bytes hold what software wrote; active bytes drive the muxes.
    reg [7:0] stage_b_r, stage_c_r, stage_d_r;
    reg [7:0] pin_b_r, pin_c_r, pin_d_r;
    reg alter_r;
    reg [7:0] last_echo_r;
    reg [7:0] last_status_r;

    function [7:0] merge_byte;
        input [7:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_byte = strb[0] ? data[7:0] : old_val;
        end
    endfunction

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    // Address and data are taken together only when both are offered, so the
    // slave never has to hold one half while waiting for the other.
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;

    // The write response stands until bready, and no new write is taken
    // meanwhile, so at most one write is ever in flight.

    wire cmd_hit = wr_go && (s_axi_awaddr == `GPSL_ADDR_CMD) && s_axi_wstrb[1]
        && s_axi_wdata[`GPSL_CMD_GO_BIT];
    // A command word may carry the alter flag in its low byte; without that
    // lane the flag stored by an earlier write decides.
    wire cmd_alter = s_axi_wstrb[0] ? s_axi_wdata[`GPSL_CMD_ALTER_BIT] : alter_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            stage_b_r <= `GPSL_PIN_RESET;
            stage_c_r <= `GPSL_PIN_RESET;
            stage_d_r <= `GPSL_PIN_RESET;
            pin_b_r <= `GPSL_PIN_RESET;
            pin_c_r <= `GPSL_PIN_RESET;
            pin_d_r <= `GPSL_PIN_RESET;
            alter_r <= 1'b0;
            last_echo_r <= 8'h00;
            last_status_r <= 8'h00;
            resp_valid <= 1'b0;
            resp_echo <= 8'h00;
            resp_status <= 8'h00;
        end else begin
            resp_valid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (s_axi_awaddr)
                    `GPSL_ADDR_CMD: begin
                        if (s_axi_wstrb[0]) begin
                            alter_r <= s_axi_wdata[`GPSL_CMD_ALTER_BIT];
                        end
                    end
                    `GPSL_ADDR_PINB: stage_b_r <= merge_byte(stage_b_r, s_axi_wdata, s_axi_wstrb);
                    `GPSL_ADDR_PINC: stage_c_r <= merge_byte(stage_c_r, s_axi_wdata, s_axi_wstrb);
                    `GPSL_ADDR_PIND: stage_d_r <= merge_byte(stage_d_r, s_axi_wdata, s_axi_wstrb);
                    // Writes to the read-only words answer OKAY and change nothing.
                    `GPSL_ADDR_STATUS, `GPSL_ADDR_PINS_IN: s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
            if (cmd_hit) begin
                if (cmd_alter) begin
                    pin_b_r <= stage_b_r;
                    pin_c_r <= stage_c_r;
                    pin_d_r <= stage_d_r;
                end
                // Nothing in this block can refuse a pin setting, so every
                // accepted command answers success.
                resp_valid <= 1'b1;
                resp_echo <= `GPSL_RESP_ECHO;
                resp_status <= `GPSL_RESP_OK;
                last_echo_r <= `GPSL_RESP_ECHO;
                last_status_r <= `GPSL_RESP_OK;
            end
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    // A new read is taken only once the previous answer has been accepted.
    // The data register keeps its value after the handshake, so a master
    // that samples late still sees the word it asked for.
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `GPSL_ADDR_CMD: s_axi_rdata <= {24'h000000, alter_r, 7'h00};
                    `GPSL_ADDR_STATUS: s_axi_rdata <= {16'h0000, last_status_r, last_echo_r};
                    `GPSL_ADDR_PINB: s_axi_rdata <= {16'h0000, pin_b_r, stage_b_r};
                    `GPSL_ADDR_PINC: s_axi_rdata <= {16'h0000, pin_c_r, stage_c_r};
                    `GPSL_ADDR_PIND: s_axi_rdata <= {16'h0000, pin_d_r, stage_d_r};
                    `GPSL_ADDR_PINS_IN: s_axi_rdata <= {29'h00000000, general_pin_d_in,
                        general_pin_c_in, general_pin_b_in};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Pin muxes
    // ----------------------------------------
    // Outputs are registered so that a settings change reaches all three
    // pins on the same edge. Undefined selector codes leave the pin floating.
    // Dedicated and alternate sources pass through the same flip-flop, so a
    // pin output only ever changes on a clock edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            general_pin_b_out <= 1'b0;
            general_pin_b_oe_n <= 1'b1;
            analog_input_first_en <= 1'b0;
            edge_detect_en <= 1'b0;
            edge_detect_in <= 1'b0;
            general_pin_c_out <= 1'b0;
            general_pin_c_oe_n <= 1'b1;
            analog_input_second_en <= 1'b0;
            general_pin_d_out <= 1'b0;
            general_pin_d_oe_n <= 1'b1;
            analog_input_third_en <= 1'b0;
        end else begin
            // ----------------------------------------
            // Pin b
            // ----------------------------------------
            analog_input_first_en <= (pin_b_r[2:0] == `GPSL_FUNC_ALT0);
            edge_detect_en <= (pin_b_r[2:0] == `GPSL_FUNC_ALT2);
            // The edge detector watches a registered copy of the pin, so it
            // never sees a level that changed within the current cycle.
            edge_detect_in <= general_pin_b_in;
            case (pin_b_r[2:0])
                `GPSL_FUNC_GPIO: begin
                    // The level follows bit 4 even while the pin is an input, so
                    // it is already in place when software turns the pin around.
                    general_pin_b_out <= pin_b_r[`GPSL_PIN_LEVEL_BIT];
                    general_pin_b_oe_n <= pin_b_r[`GPSL_PIN_DIR_BIT];
                end
                `GPSL_FUNC_DEDICATED: begin
                    general_pin_b_out <= clock_output_src;
                    general_pin_b_oe_n <= 1'b0;
                end
                `GPSL_FUNC_ALT1: begin
                    general_pin_b_out <= transmit_activity_indicator;
                    general_pin_b_oe_n <= 1'b0;
                end
                default: begin
                    general_pin_b_out <= 1'b0;
                    general_pin_b_oe_n <= 1'b1;
                end
            endcase

            // ----------------------------------------
            // Pin c
            // ----------------------------------------
            analog_input_second_en <= (pin_c_r[2:0] == `GPSL_FUNC_ALT0);
            case (pin_c_r[2:0])
                `GPSL_FUNC_GPIO: begin
                    general_pin_c_out <= pin_c_r[`GPSL_PIN_LEVEL_BIT];
                    general_pin_c_oe_n <= pin_c_r[`GPSL_PIN_DIR_BIT];
                end
                `GPSL_FUNC_DEDICATED: begin
                    general_pin_c_out <= usb_configured_indicator;
                    general_pin_c_oe_n <= 1'b0;
                end
                `GPSL_FUNC_ALT1: begin
                    general_pin_c_out <= analog_output_first;
                    general_pin_c_oe_n <= 1'b0;
                end
                default: begin
                    general_pin_c_out <= 1'b0;
                    general_pin_c_oe_n <= 1'b1;
                end
            endcase

            // ----------------------------------------
            // Pin d
            // ----------------------------------------
            analog_input_third_en <= (pin_d_r[2:0] == `GPSL_FUNC_ALT0);
            case (pin_d_r[2:0])
                `GPSL_FUNC_GPIO: begin
                    general_pin_d_out <= pin_d_r[`GPSL_PIN_LEVEL_BIT];
                    general_pin_d_oe_n <= pin_d_r[`GPSL_PIN_DIR_BIT];
                end
                `GPSL_FUNC_DEDICATED: begin
                    general_pin_d_out <= serial_bus_activity_indicator;
                    general_pin_d_oe_n <= 1'b0;
                end
                `GPSL_FUNC_ALT1: begin
                    general_pin_d_out <= analog_output_second;
                    general_pin_d_oe_n <= 1'b0;
                end
                default: begin
                    general_pin_d_out <= 1'b0;
                    general_pin_d_oe_n <= 1'b1;
                end
            endcase
        end
    end

endmodule

// [gpsl_loader_asserts.sv]
// Purpose: Port checks for the general-pin settings loader.
// Assumes: Pins follow the active settings one cycle late.
// Notes: Staged and active settings are mirrored from bus writes.
`timescale 1ns/1ps
`include "gpsl_regs.vh"
module gpsl_loader_asserts (
    // Clock, reset and write channels
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    // Sources and pins
    input wire logic clock_output_src,
    input wire logic analog_output_first,
    input wire logic serial_bus_activity_indicator,
    input wire logic general_pin_b_out,
    input wire logic general_pin_b_oe_n,
    input wire logic general_pin_c_out,
    input wire logic general_pin_c_oe_n,
    input wire logic general_pin_d_out,
    input wire logic general_pin_d_oe_n,
    input wire logic analog_input_first_en,
    // Response
    input wire logic resp_valid,
    input wire logic [7:0] resp_echo,
    input wire logic [7:0] resp_status
);
    // ----------------------------------------
    // Settings mirror
    // ----------------------------------------
    logic [7:0] sb_r, sc_r, sd_r, ab_r, ac_r, ad_r;
    logic alt_r;
    wire wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    wire go = wr && s_axi_awaddr == `GPSL_ADDR_CMD && s_axi_wstrb[1] && s_axi_wdata[8];
    wire alt = s_axi_wstrb[0] ? s_axi_wdata[7] : alt_r;
    always @(posedge aclk) begin
        if (!aresetn) begin
            {sb_r, sc_r, sd_r, ab_r, ac_r, ad_r} <= {6{`GPSL_PIN_RESET}};
            alt_r <= 1'h0;
        end else begin
            if (wr && s_axi_wstrb[0] && s_axi_awaddr == `GPSL_ADDR_CMD) alt_r <= s_axi_wdata[7];
            if (wr && s_axi_wstrb[0] && s_axi_awaddr == `GPSL_ADDR_PINB) sb_r <= s_axi_wdata[7:0];
            if (wr && s_axi_wstrb[0] && s_axi_awaddr == `GPSL_ADDR_PINC) sc_r <= s_axi_wdata[7:0];
            if (wr && s_axi_wstrb[0] && s_axi_awaddr == `GPSL_ADDR_PIND) sd_r <= s_axi_wdata[7:0];
            if (go && alt) begin
                ab_r <= sb_r;
                ac_r <= sc_r;
                ad_r <= sd_r;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_plain_io_a: assert property ((ab_r[2:0] == `GPSL_FUNC_GPIO) |=>
        general_pin_b_out == $past(ab_r[4]) && general_pin_b_oe_n == $past(ab_r[3]))
        else $error("pin b plain io wrong");
    c_plain_io_a: assert property ((ac_r[2:0] == `GPSL_FUNC_GPIO) |=>
        general_pin_c_out == $past(ac_r[4]) && general_pin_c_oe_n == $past(ac_r[3]))
        else $error("pin c plain io wrong");
    d_plain_io_a: assert property ((ad_r[2:0] == `GPSL_FUNC_GPIO) |=>
        general_pin_d_out == $past(ad_r[4]) && general_pin_d_oe_n == $past(ad_r[3]))
        else $error("pin d plain io wrong");
    b_clock_out_a: assert property ((ab_r[2:0] == 3'h1) |=>
        general_pin_b_out == $past(clock_output_src) && !general_pin_b_oe_n)
        else $error("pin b clock output wrong");
    b_analog_in_a: assert property ((ab_r[2:0] == 3'h2) |=>
        analog_input_first_en && general_pin_b_oe_n) else $error("pin b analog input wrong");
    c_analog_out_a: assert property ((ac_r[2:0] == 3'h3) |=>
        general_pin_c_out == $past(analog_output_first) && !general_pin_c_oe_n)
        else $error("pin c analog output wrong");
    d_bus_led_a: assert property ((ad_r[2:0] == 3'h1) |=>
        general_pin_d_out == $past(serial_bus_activity_indicator) && !general_pin_d_oe_n)
        else $error("pin d bus indicator wrong");
    resp_echo_a: assert property (go |-> ##1 resp_valid &&
        resp_echo == `GPSL_RESP_ECHO && resp_status == `GPSL_RESP_OK)
        else $error("response missing or wrong");
    resp_cause_a: assert property (resp_valid |-> $past(go))
        else $error("response without command");
    alter_cv: cover property (go && alt);
    keep_cv: cover property (go && !alt);
    edge_cv: cover property (ab_r[2:0] == 3'h4);
endmodule
bind gpsl_loader gpsl_loader_asserts gpsl_loader_asserts_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .clock_output_src(clock_output_src), .analog_output_first(analog_output_first),
    .serial_bus_activity_indicator(serial_bus_activity_indicator),
    .general_pin_b_out(general_pin_b_out), .general_pin_b_oe_n(general_pin_b_oe_n),
    .general_pin_c_out(general_pin_c_out), .general_pin_c_oe_n(general_pin_c_oe_n),
    .general_pin_d_out(general_pin_d_out), .general_pin_d_oe_n(general_pin_d_oe_n),
    .analog_input_first_en(analog_input_first_en), .resp_valid(resp_valid),
    .resp_echo(resp_echo), .resp_status(resp_status));

// [gpsl_pin_world.sv]
// Purpose: Outside world of the three general pins.
// Assumes: One clock.
// Notes: Source signals toggle at different rates.
`timescale 1ns/1ps
module gpsl_pin_world (
    // Clock
    input wire logic aclk,
    // Pin drivers and outside levels
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] ext_lvl,
    // Pin levels and function sources
    output logic [2:0] pin_in,
    output logic [5:0] src
);
    logic [5:0] cnt_r = 6'h00;
    // Distinct rates make a wrong mux choice visible within a few cycles.
    always @(posedge aclk) cnt_r <= cnt_r + 6'h01;
    assign src = cnt_r;
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule

// [gp_pin_settings_loader_test.sv]
// Purpose: Self-checking bench for the general-pin settings loader.
// Assumes: Pins settle one cycle after a command is taken.
// Notes: Write and read responses are always accepted.
`timescale 1ns/1ps
`include "gpsl_regs.vh"
module gp_pin_settings_loader_test;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0] wstrb = 4'h0;
    logic [2:0] ext_lvl = 3'h5;
    logic [1:0] rsp;
    wire awready, wready, bvalid, arready, rvalid, resp_valid, edge_en, edge_in;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] resp_echo, resp_status;
    wire [2:0] pin_out, oe_n, pin_in, ana_en;
    wire [5:0] src;
    int miscompares = 0, total_checks = 0, cycles = 0;
    always #50 aclk = ~aclk;
    gpsl_loader gpsl_loader_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .clock_output_src(src[0]),
        .transmit_activity_indicator(src[1]), .usb_configured_indicator(src[2]),
        .serial_bus_activity_indicator(src[3]), .analog_output_first(src[4]),
        .analog_output_second(src[5]), .general_pin_b_in(pin_in[0]),
        .general_pin_b_out(pin_out[0]), .general_pin_b_oe_n(oe_n[0]),
        .analog_input_first_en(ana_en[0]), .edge_detect_en(edge_en),
        .edge_detect_in(edge_in), .general_pin_c_in(pin_in[1]),
        .general_pin_c_out(pin_out[1]), .general_pin_c_oe_n(oe_n[1]),
        .analog_input_second_en(ana_en[1]), .general_pin_d_in(pin_in[2]),
        .general_pin_d_out(pin_out[2]), .general_pin_d_oe_n(oe_n[2]),
        .analog_input_third_en(ana_en[2]), .resp_valid(resp_valid),
        .resp_echo(resp_echo), .resp_status(resp_status));
    gpsl_pin_world gpsl_pin_world_i (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(oe_n),
        .ext_lvl(ext_lvl), .pin_in(pin_in), .src(src));
    // ----------------------------------------
    // Bus tasks and compares
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        do @(posedge aclk); while (bvalid !== 1'h1);
        rsp = bresp;
    endtask
    task automatic rdw(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rd = rdata;
        rsp = rresp;
    endtask
    task automatic stg(input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
        wr(`GPSL_ADDR_PINB, {24'h0, b}, 4'h1);
        wr(`GPSL_ADDR_PINC, {24'h0, c}, 4'h1);
        wr(`GPSL_ADDR_PIND, {24'h0, d}, 4'h1);
    endtask
    task automatic cmd(input logic alt);
        wr(`GPSL_ADDR_CMD, {23'h0, 1'h1, alt, 7'h0}, 4'h3);
        chk("response", 32'h00016000, {15'h0, resp_valid, resp_echo, resp_status});
        repeat (2) @(posedge aclk);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            results();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rdw(`GPSL_ADDR_PINB);
        chk("pin b active", {24'h0, `GPSL_PIN_RESET}, {24'h0, rd[15:8]});
        stg(8'h10, 8'h00, 8'h18);
        cmd(1'h1);
        chk("pin levels", 32'h5, {29'h0, pin_out});
        chk("pin drives", 32'h4, {29'h0, oe_n});
        chk("edge copy", 32'h1, {31'h0, edge_in});
        rdw(`GPSL_ADDR_PINS_IN);
        chk("pin inputs", 32'h5, {29'h0, rd[2:0]});
        rdw(`GPSL_ADDR_STATUS);
        chk("status", 32'h60, {16'h0, rd[15:0]});
        stg(8'h08, 8'h08, 8'h10);
        cmd(1'h0);
        chk("kept drives", 32'h4, {29'h0, oe_n});
        cmd(1'h1);
        chk("new drives", 32'h3, {29'h0, oe_n});
        chk("new levels", 32'h4, {29'h0, pin_out});
        for (int k = 1; k < 8; k++) begin
            stg(8'h08 | k[7:0], 8'h08 | k[7:0], 8'h08 | k[7:0]);
            cmd(1'h1);
            chk("func drives", {29'h0, {3{!(k == 1 || k == 3)}}}, {29'h0, oe_n});
            chk("func enables", {28'h0, {3{k == 2}}, k == 4}, {28'h0, ana_en, edge_en});
        end
        rdw(8'h40);
        chk("unmapped read", 32'h2, {30'h0, rsp});
        wr(8'h40, 32'h0, 4'hF);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        results();
    end
endmodule
